// ==== design/ssp_defines.vh ====
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH
// Device addresses selected by the address select strap.
`define SSP_ADDR_STRAP_LO 7'h55
`define SSP_ADDR_STRAP_HI 7'h33
// Bits in one transfer unit, and the last bit index.
`define SSP_BYTE_BITS     4'h8
`define SSP_LAST_BIT      3'h7
// Depth of the pin input synchroniser.
`define SSP_SYNC_STAGES   3
`endif

// ==== design/ssp_pin_sync.v ====
`timescale 1ns/1ps
`include "ssp_defines.vh"
// Three-stage synchroniser; the level changes only when stages two and
// three agree, so the first stage is never looked at by any gate.
module ssp_pin_sync (
   // Clock and reset.
   input  wire clk_sys,
   input  wire reset,
   // Asynchronous pin and its filtered level.
   input  wire pin_in,
   output reg  level_r
);
   reg [`SSP_SYNC_STAGES-1:0] stage_r;   // Shift chain, bit 0 first.

   // Shift the pin in and update the level on agreement.
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         stage_r <= 3'h7;
         level_r <= 1'b1;
      end else begin
         stage_r <= {stage_r[1:0], pin_in};
         if (stage_r[1] == stage_r[2]) begin
            level_r <= stage_r[2];
         end
      end
   end
endmodule

// ==== design/ssp_slave.v ====
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_slave (
   // Main clock and reset.
   input  wire       clk_sys,
   input  wire       reset,
   // Address select strap.
   input  wire       addr_sel,
   // Serial bus pins; data is open drain.
   input  wire       scl_in,
   input  wire       sda_in,
   output reg        sda_out_r,
   output reg        sda_oe_n_r,
   // Internal register file access.
   output reg [7:0]  reg_addr_r,
   output reg [7:0]  reg_wdata_r,
   output reg        reg_wr_r,
   output reg        reg_rd_r,
   input  wire [7:0] reg_rdata
);
   // One-hot states of the byte engine.
   localparam [5:0] ST_IDLE = 6'h01; // Waiting for a start.
   localparam [5:0] ST_RECV = 6'h02; // Shifting in a byte.
   localparam [5:0] ST_ACK  = 6'h04; // Driving our acknowledge.
   localparam [5:0] ST_SEND = 6'h08; // Shifting out a byte.
   localparam [5:0] ST_MACK = 6'h10; // Sampling the master's answer.
   localparam [5:0] ST_SKIP = 6'h20; // Ignoring until next start.

   // Byte roles within a transaction.
   localparam [1:0] PH_DEV = 2'h0;   // Device address byte.
   localparam [1:0] PH_REG = 2'h1;   // Register address byte.
   localparam [1:0] PH_DAT = 2'h2;   // Write data byte.

   wire       scl_s;                 // Synchronised clock level.
   wire       sda_s;                 // Synchronised data level.
   reg        scl_d_r;               // Previous clock level.
   reg        sda_d_r;               // Previous data level.
   reg        scl_dd_r;              // Clock level two samples back.
   reg [5:0]  state_r;               // Engine state.
   reg [1:0]  phase_r;               // Role of the current byte.
   reg [7:0]  shift_r;               // Byte shifter.
   reg [3:0]  bit_cnt_r;             // Bits moved so far.
   reg        strap_r;               // Captured address select.
   reg        strap_done_r;          // Strap has been captured.
   reg        is_read_r;             // Current transfer is a read.
   reg        ack_hi_r;              // Ack clock high phase seen.

   wire scl_rise = scl_s & ~scl_d_r;
   wire scl_fall = ~scl_s & scl_d_r;
   // Data is taken one sample after the clock rise: our own release of
   // the line can trail that rise by a sample at a fast bus clock.
   wire scl_samp = scl_s & scl_d_r & ~scl_dd_r;
   // Start and stop need the clock high for three samples, so a data
   // edge trailing the clock rise by one sample is not a bus condition.
   wire start_ev = scl_s & scl_d_r & scl_dd_r & sda_d_r & ~sda_s;
   wire stop_ev  = scl_s & scl_d_r & scl_dd_r & ~sda_d_r & sda_s;

   // Chosen device address from the held strap.
   function [6:0] own_addr;
      input sel;
      begin
         own_addr = sel ? `SSP_ADDR_STRAP_HI : `SSP_ADDR_STRAP_LO;
      end
   endfunction

   // Both pins pass the three-stage synchroniser first.
   ssp_pin_sync u_scl_sync (
      .clk_sys (clk_sys),
      .reset   (reset),
      .pin_in  (scl_in),
      .level_r (scl_s)
   );
   ssp_pin_sync u_sda_sync (
      .clk_sys (clk_sys),
      .reset   (reset),
      .pin_in  (sda_in),
      .level_r (sda_s)
   );

   // The strap is caught on the first clock after reset release and
   // then frozen, so later strap movement cannot move the address.
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         strap_r      <= 1'b0;
         strap_done_r <= 1'b0;
      end else if (!strap_done_r) begin
         strap_r      <= addr_sel;
         strap_done_r <= 1'b1;
      end
   end

   // Main engine: everything, bus clock included, is sampled on clk_sys;
   // the bus clock is only a data input here, never a clock.
   // The slave only ever releases or pulls data low.
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         scl_d_r     <= 1'b1;
         sda_d_r     <= 1'b1;
         scl_dd_r    <= 1'b1;
         state_r     <= ST_IDLE;
         phase_r     <= PH_DEV;
         shift_r     <= 8'h00;
         bit_cnt_r   <= 4'h0;
         is_read_r   <= 1'b0;
         ack_hi_r    <= 1'b0;
         sda_out_r   <= 1'b0;
         sda_oe_n_r  <= 1'b1;
         reg_addr_r  <= 8'h00;
         reg_wdata_r <= 8'h00;
         reg_wr_r    <= 1'b0;
         reg_rd_r    <= 1'b0;
      end else begin
         scl_d_r  <= scl_s;
         sda_d_r  <= sda_s;
         scl_dd_r <= scl_d_r;
         reg_wr_r <= 1'b0;
         reg_rd_r <= 1'b0;
         if (start_ev) begin
            // A start, repeated or not, always rearms address decode.
            state_r    <= ST_RECV;
            phase_r    <= PH_DEV;
            bit_cnt_r  <= 4'h0;
            sda_oe_n_r <= 1'b1;
         end else if (stop_ev) begin
            state_r    <= ST_IDLE;
            sda_oe_n_r <= 1'b1;
         end else begin
            case (state_r)
               ST_RECV: begin
                  if (scl_samp) begin
                     // Msb arrives first and shifts toward the top.
                     shift_r   <= {shift_r[6:0], sda_s};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end else if (scl_fall &&
                               bit_cnt_r == `SSP_BYTE_BITS) begin
                     bit_cnt_r <= 4'h0;
                     ack_hi_r  <= 1'b0;
                     if (phase_r == PH_DEV &&
                         shift_r[7:1] != own_addr(strap_r)) begin
                        // Wrong address: stay off the bus.
                        state_r <= ST_SKIP;
                     end else begin
                        // Pull data low for the ack bit.
                        state_r    <= ST_ACK;
                        sda_oe_n_r <= 1'b0;
                        sda_out_r  <= 1'b0;
                        case (phase_r)
                           PH_DEV: begin
                              is_read_r <= shift_r[0];
                              if (shift_r[0]) begin
                                 reg_rd_r <= 1'b1;
                              end
                           end
                           PH_REG: begin
                              reg_addr_r <= shift_r;
                           end
                           default: begin
                              reg_wdata_r <= shift_r;
                              reg_wr_r    <= 1'b1;
                           end
                        endcase
                     end
                  end
               end
               ST_ACK: begin
                  // Hold low until the falling edge after ack high.
                  if (scl_rise) begin
                     ack_hi_r <= 1'b1;
                  end else if (scl_fall && ack_hi_r) begin
                     if (is_read_r && phase_r == PH_DEV) begin
                        state_r    <= ST_SEND;
                        shift_r    <= reg_rdata;
                        sda_out_r  <= 1'b0;
                        sda_oe_n_r <= ~reg_rdata[7] ? 1'b0 : 1'b1;
                        bit_cnt_r  <= 4'h1;
                     end else begin
                        // Further write bytes overwrite the data slot;
                        // the master closes with stop or restart.
                        state_r    <= ST_RECV;
                        sda_oe_n_r <= 1'b1;
                        phase_r    <= (phase_r == PH_DEV) ? PH_REG : PH_DAT;
                     end
                  end
               end
               ST_SEND: begin
                  // Present the next bit on each falling clock.
                  if (scl_fall) begin
                     if (bit_cnt_r == `SSP_BYTE_BITS) begin
                        state_r    <= ST_MACK;
                        sda_oe_n_r <= 1'b1;
                     end else begin
                        sda_oe_n_r <= ~shift_r[3'h7 - bit_cnt_r[2:0]] ?
                                      1'b0 : 1'b1;
                        bit_cnt_r  <= bit_cnt_r + 4'h1;
                     end
                  end
               end
               ST_MACK: begin
                  // Not-acknowledge ends the read; ack sends the same
                  // register again as a simple continuation.
                  if (scl_samp) begin
                     ack_hi_r <= ~sda_s;
                  end else if (scl_fall) begin
                     if (ack_hi_r) begin
                        state_r    <= ST_SEND;
                        reg_rd_r   <= 1'b1;
                        shift_r    <= reg_rdata;
                        sda_oe_n_r <= ~reg_rdata[7] ? 1'b0 : 1'b1;
                        bit_cnt_r  <= 4'h1;
                     end else begin
                        state_r <= ST_SKIP;
                     end
                  end
               end
               ST_IDLE: begin
                  sda_oe_n_r <= 1'b1;
               end
               ST_SKIP: begin
                  sda_oe_n_r <= 1'b1;
               end
               default: begin
                  state_r    <= ST_IDLE;
                  sda_oe_n_r <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule

// ==== tb/ssp_bus_master.sv ====
`timescale 1ns/1ps
// Bus master model; each bus bit takes four quarters of Q ns.
module ssp_bus_master #(parameter Q = 12) (
   // Clock, data pull-down and the resolved data line.
   output reg  scl = 1'b1,
   output reg  pull_low = 1'b0,
   input  wire sda
);
   // Data moves only while the clock is low; it is read mid-high.
   task bit_x(input b, output r);
      pull_low = !b;
      #Q scl = 1'b1;
      #Q r = sda;
      #Q scl = 1'b0;
      #Q;
   endtask
   // Data edge with the clock high: falling starts, rising stops.
   task cond(input v);
      pull_low = v;
      #Q scl = 1'b1;
      #Q pull_low = !v;
      #Q scl = v;
      #Q;
   endtask
   task xfer(input [7:0] d, input ma, output [7:0] q, output sa);
      integer i;
      for (i = 7; i >= 0; i = i - 1)
         bit_x(d[i], q[i]);
      bit_x(ma, sa);
   endtask
endmodule

// ==== tb/ssp_chk_properties.sv ====
`timescale 1ns/1ps
module ssp_chk (
   // Clock and reset.
   input wire clk_sys,
   input wire reset,
   // Bus pins and register strobes.
   input wire scl_in,
   input wire sda_in,
   input wire sda_out_r,
   input wire sda_oe_n_r,
   input wire reg_wr_r,
   input wire reg_rd_r
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   property p_od; !sda_out_r; endproperty
   a_od: assert property (p_od) else $error("drive value high");
   property p_ack; $rose(scl_in) && !sda_oe_n_r |=>
      !sda_oe_n_r[*8]; endproperty
   a_ack: assert property (p_ack) else $error("ack released");
   property p_mv; $changed(sda_oe_n_r) |-> !$past(scl_in); endproperty
   a_mv: assert property (p_mv) else $error("data moved, clock high");
   property p_sta; scl_in && $past(scl_in, 2) && $fell(sda_in) |=>
      sda_oe_n_r[*8]; endproperty
   a_sta: assert property (p_sta) else $error("driven after start");
   property p_sto; scl_in && $past(scl_in, 2) && $rose(sda_in) |=>
      sda_oe_n_r[*8]; endproperty
   a_sto: assert property (p_sto) else $error("driven after stop");
   property p_wr; reg_wr_r |-> !$past(scl_in) ##1 !reg_wr_r; endproperty
   a_wr: assert property (p_wr) else $error("write pulse");
   property p_rd; reg_rd_r |-> !$past(scl_in) ##1 !reg_rd_r; endproperty
   a_rd: assert property (p_rd) else $error("read pulse");
   property p_wa; reg_wr_r |-> ##[0:6] !sda_oe_n_r; endproperty
   a_wa: assert property (p_wa) else $error("write not acked");
endmodule
bind ssp_slave ssp_chk u_chk (.clk_sys(clk_sys), .reset(reset),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out_r(sda_out_r),
   .sda_oe_n_r(sda_oe_n_r), .reg_wr_r(reg_wr_r), .reg_rd_r(reg_rd_r));

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "ssp_defines.vh"
module testbench;
   reg        clk_sys = 1'b0;
   reg        reset = 1'b1;
   reg        addr_sel = 1'b0;
   reg  [7:0] mem [0:255];
   reg  [7:0] ra, q;
   reg  [6:0] da;
   reg        a;
   integer    errors = 0, n_compared = 0, s, k;
   wire       scl, pl, oe_n, wr;
   wire [7:0] radr, wdat;
   // Open-drain data line with a pull-up.
   wire       sda = !(pl || !oe_n);
   always #2.5 clk_sys = !clk_sys;
   ssp_bus_master m (.scl(scl), .pull_low(pl), .sda(sda));
   ssp_slave uut (.clk_sys(clk_sys), .reset(reset), .addr_sel(addr_sel),
      .scl_in(scl), .sda_in(sda), .sda_out_r(), .sda_oe_n_r(oe_n),
      .reg_addr_r(radr), .reg_wdata_r(wdat), .reg_wr_r(wr),
      .reg_rd_r(), .reg_rdata(mem[radr]));
   // Register file behind the port.
   always @(posedge clk_sys) if (wr === 1'b1) mem[radr] <= wdat;
   task chk(input string n, input [7:0] e, input [7:0] g);
      n_compared = n_compared + 1;
      if (g !== e) begin
         errors = errors + 1;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task wrap_up;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task tx(input [7:0] d, input e);
      m.xfer(d, 1'b1, q, a);
      chk("ack", {7'h00, e}, {7'h00, a});
   endtask
   task head(input [6:0] ad, input e);
      m.cond(1'b0);
      tx({ad, 1'b0}, e);
      tx(ra, e);
   endtask
   initial begin
      for (k = 0; k < 256; k = k + 1)
         mem[k] = 8'h00;
      k = $urandom(34);
      for (s = 0; s < 2; s = s + 1) begin
         if (s != 0) begin
            @(posedge clk_sys);
            #1 reset = 1'b1;
         end
         addr_sel = s[0];
         da = s ? `SSP_ADDR_STRAP_HI : `SSP_ADDR_STRAP_LO;
         repeat (12) @(posedge clk_sys);
         #1 reset = 1'b0;
         repeat (4) @(posedge clk_sys);
         #1 addr_sel = !s[0];
         k = $urandom;
         ra = s ? 8'hFF : k[15:8];
         head(da, 1'b0);
         tx(k[7:0], 1'b0);
         m.cond(1'b1);
         chk("written", k[7:0], mem[ra]);
         head(da, 1'b0);
         m.cond(1'b0);
         tx({da, 1'b1}, 1'b0);
         m.xfer(8'hFF, 1'b1, q, a);
         chk("read", k[7:0], q);
         head(s ? `SSP_ADDR_STRAP_LO : `SSP_ADDR_STRAP_HI, 1'b1);
         tx(~k[7:0], 1'b1);
         m.cond(1'b1);
         chk("kept", k[7:0], mem[ra]);
      end
      wrap_up;
   end
endmodule
